/* rtl/pdm_power_down_control.sv */
`timescale 1ns/1ps
`include "pdm_cfg.svh"
module pdm_power_down_control
    import pdm_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       mode_wr,
    input  wire logic [1:0] mode_wdata,
    input  wire logic       go_wr,
    input  wire pdm_wake_t  wake,
    output logic [1:0]      power_down_mode_select,
    output logic            power_down_go,
    output logic            sleeping,
    output logic            digital_regulator_on,
    output logic            reconfig_required
);
    // Power state, current and next
    pdm_state_t state_r;
    pdm_state_t state_nxt;
    pdm_state_t mode_state;

    // Mode field and go bit
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic       go_r;
    logic       go_nxt;

    // Status flags
    logic       sleep_r;
    logic       sleep_nxt;
    logic       reg_on_r;
    logic       reg_on_nxt;
    logic       reconf_r;
    logic       reconf_nxt;

    // Qualified requests
    logic       is_active;
    logic       is_off_state;
    logic       mode_accept;
    logic       go_seen;
    logic       go_accept;
    logic       wake_hit;
    logic       wake_accept;

    pdm_wake_filter u_filter
    (
        .state    (state_r),
        .wake     (wake),
        .wake_hit (wake_hit)
    );

    // Request qualification
    assign is_active    = (state_r == PDM_ACTIVE);
    assign is_off_state = (state_r == PDM_MEDIUM)
                          || (state_r == PDM_DEEP);
    assign mode_accept  = mode_wr && is_active;
    assign go_seen      = go_wr && is_active;
    assign go_accept    = go_seen && (mode_r != `PDM_MODE_ACTIVE);
    assign wake_accept  = !is_active && wake_hit;
    assign mode_state   = pdm_state_t'(mode_r);

    // Mode field, written only while active and kept across sleep
    always_comb
    begin
        mode_nxt = mode_r;
        unique case (state_r)
            PDM_ACTIVE:
            begin
                if (mode_accept)
                    mode_nxt = mode_wdata;
            end
            PDM_LIGHT,
            PDM_MEDIUM,
            PDM_DEEP:
            begin
                mode_nxt = mode_r;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            mode_r <= `PDM_MODE_RST;
        else
            mode_r <= mode_nxt;
    end

    // Power state sequencing
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            PDM_ACTIVE:
            begin
                if (go_accept)
                    state_nxt = mode_state;
            end
            PDM_LIGHT,
            PDM_MEDIUM,
            PDM_DEEP:
            begin
                if (wake_accept)
                    state_nxt = PDM_ACTIVE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            state_r <= PDM_ACTIVE;
        else
            state_r <= state_nxt;
    end

    // Go bit: set by an accepted write, cleared on wake
    always_comb
    begin
        go_nxt = go_r;
        unique case (state_r)
            PDM_ACTIVE:
            begin
                if (go_accept)
                    go_nxt = 1'b1;
            end
            PDM_LIGHT,
            PDM_MEDIUM,
            PDM_DEEP:
            begin
                if (wake_accept)
                    go_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            go_r <= `PDM_GO_RST;
        else
            go_r <= go_nxt;
    end

    // Sleep flag follows the next state
    always_comb
    begin
        sleep_nxt = 1'b0;
        unique case (state_nxt)
            PDM_ACTIVE: sleep_nxt = 1'b0;
            PDM_LIGHT,
            PDM_MEDIUM,
            PDM_DEEP:   sleep_nxt = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            sleep_r <= `PDM_SLEEP_RST;
        else
            sleep_r <= sleep_nxt;
    end

    // Digital regulator: on while active or light, off otherwise
    always_comb
    begin
        reg_on_nxt = 1'b1;
        unique case (state_nxt)
            PDM_ACTIVE,
            PDM_LIGHT:  reg_on_nxt = 1'b1;
            PDM_MEDIUM,
            PDM_DEEP:   reg_on_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_on_r <= `PDM_REG_ON_RST;
        else
            reg_on_r <= reg_on_nxt;
    end

    // Reconfiguration flag: set by a cycle with the regulator off,
    // cleared by the next go write while active
    always_comb
    begin
        reconf_nxt = reconf_r;
        unique case (state_r)
            PDM_ACTIVE:
            begin
                if (go_seen)
                    reconf_nxt = 1'b0;
            end
            PDM_LIGHT:
            begin
                reconf_nxt = reconf_r;
            end
            PDM_MEDIUM,
            PDM_DEEP:
            begin
                reconf_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reconf_r <= `PDM_RECONF_RST;
        else
            reconf_r <= reconf_nxt;
    end

    // Outputs
    assign power_down_mode_select = mode_r;
    assign power_down_go          = go_r;
    assign sleeping               = sleep_r;
    assign digital_regulator_on   = reg_on_r;
    assign reconfig_required      = reconf_r;
endmodule : pdm_power_down_control

/* rtl/pdm_wake_filter.sv */
`timescale 1ns/1ps
`include "pdm_cfg.svh"
module pdm_wake_filter
    import pdm_pkg::*;
(
    input  wire pdm_state_t state,
    input  wire pdm_wake_t  wake,
    output logic            wake_hit
);
    always_comb
    begin
        unique case (state)
            PDM_ACTIVE: wake_hit = 1'b0;
            PDM_LIGHT,
            PDM_MEDIUM: wake_hit = wake.hw_reset | wake.sleep_timer
                                   | wake.ext_int;
            PDM_DEEP:   wake_hit = wake.hw_reset | wake.ext_int;
        endcase
    end
endmodule : pdm_wake_filter

/* shared/pdm_cfg.svh */
`ifndef PDM_CFG_SVH
`define PDM_CFG_SVH
`define PDM_MODE_ACTIVE 2'h0
`define PDM_MODE_LIGHT  2'h1
`define PDM_MODE_MEDIUM 2'h2
`define PDM_MODE_DEEP   2'h3
`define PDM_MODE_RST    2'h0
`define PDM_GO_RST      1'b0
`define PDM_SLEEP_RST   1'b0
`define PDM_REG_ON_RST  1'b1
`define PDM_RECONF_RST  1'b0
`endif

/* shared/pdm_pkg.sv */
package pdm_pkg;
    typedef enum logic [1:0]
    {
        PDM_ACTIVE = 2'b00,
        PDM_LIGHT  = 2'b01,
        PDM_MEDIUM = 2'b10,
        PDM_DEEP   = 2'b11
    } pdm_state_t;

    typedef struct packed
    {
        logic hw_reset;
        logic sleep_timer;
        logic ext_int;
    } pdm_wake_t;
endpackage : pdm_pkg

/* sim/pdm_power_down_control_assertions.sv */
`timescale 1ns/1ps
module pdm_chk
    import pdm_pkg::*;
(
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       go_wr,
    input wire logic       mode_wr,
    input wire pdm_wake_t  wake,
    input wire logic [1:0] power_down_mode_select,
    input wire logic       power_down_go,
    input wire logic       sleeping,
    input wire logic       digital_regulator_on,
    input wire logic       reconfig_required
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic [1:0] md = power_down_mode_select;
    a_go_entry: assert property (
        go_wr && !power_down_go && md != 2'h0 |=> power_down_go)
        else $error("no entry");
    a_idle_mode: assert property (
        go_wr && !power_down_go && md == 2'h0 |=> !power_down_go)
        else $error("entry from mode 0");
    a_deep_timer: assert property (
        power_down_go && md == 2'h3 && wake == 3'h2 |=> power_down_go)
        else $error("deep woke on timer");
    a_ext_wake: assert property (
        power_down_go && wake.ext_int |=> !power_down_go && $stable(md))
        else $error("no wake");
    a_reg_level: assert property (
        digital_regulator_on == (!power_down_go || md == 2'h1))
        else $error("regulator wrong");
    a_sleep_go: assert property (
        sleeping == power_down_go)
        else $error("sleep flag differs from go bit");
    a_mode_hold: assert property (
        power_down_go && mode_wr |=> $stable(md))
        else $error("mode written while asleep");
    sequence s_enter_off;
        go_wr && !power_down_go && md[1] ##1 power_down_go;
    endsequence
    a_reconf_set: assert property (
        s_enter_off |=> reconfig_required)
        else $error("reconfiguration flag not set");
endmodule : pdm_chk
bind pdm_power_down_control pdm_chk u_chk
(
    .core_clk               (core_clk),
    .rst_n                  (rst_n),
    .go_wr                  (go_wr),
    .mode_wr                (mode_wr),
    .wake                   (wake),
    .power_down_mode_select (power_down_mode_select),
    .power_down_go          (power_down_go),
    .sleeping               (sleeping),
    .digital_regulator_on   (digital_regulator_on),
    .reconfig_required      (reconfig_required)
);

/* sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    import pdm_pkg::*;
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
    end end
    logic       core_clk = 0, rst_n = 0, mode_wr = 0, go_wr = 0;
    logic [1:0] mode_wdata = 0, m, power_down_mode_select;
    logic       power_down_go, sleeping;
    logic       digital_regulator_on, reconfig_required;
    logic [2:0] w;
    pdm_wake_t  wake = 0;
    int         n_mismatch = 0, checks = 0, cyc = 0;
    pdm_power_down_control u_pdm_power_down_control
    (
        .core_clk               (core_clk),
        .rst_n                  (rst_n),
        .mode_wr                (mode_wr),
        .mode_wdata             (mode_wdata),
        .go_wr                  (go_wr),
        .wake                   (wake),
        .power_down_mode_select (power_down_mode_select),
        .power_down_go          (power_down_go),
        .sleeping               (sleeping),
        .digital_regulator_on   (digital_regulator_on),
        .reconfig_required      (reconfig_required)
    );
    function automatic logic exp_hit
    (
        input logic [1:0] md,
        input pdm_wake_t  wk
    );
        return md == 2'h0 || wk.hw_reset || wk.ext_int
               || (wk.sleep_timer && md != 2'h3);
    endfunction : exp_hit
    function automatic logic exp_reg(input logic [1:0] md);
        return md < 2'h2;
    endfunction : exp_reg
    always #10 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc > 2000)
        begin
            n_mismatch++;
            final_report();
        end
    end
    task final_report;
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report
    initial
    begin
        void'($urandom(32'h53ca));
        repeat (12) @(negedge core_clk);
        rst_n = 1;
        for (int i = 0; i < 40; i++)
        begin
            m = i < 4 ? i[1:0] : 2'($urandom % 4);
            w = i < 4 ? 3'h2 : 3'($urandom % 8);
            mode_wr = 1;
            mode_wdata = m;
            @(negedge core_clk) {mode_wr, go_wr} = 2'h1;
            @(negedge core_clk) {mode_wr, go_wr} = {2{m != 2'h0}};
            mode_wdata = ~m;
            `CHK("go", m != 0, power_down_go)
            `CHK("sleep", m != 0, sleeping)
            `CHK("reg", exp_reg(m), digital_regulator_on)
            `CHK("reconf", 1'b0, reconfig_required)
            wake = w;
            @(negedge core_clk) wake = 3'h1;
            {mode_wr, go_wr} = 2'h0;
            `CHK("wake", !exp_hit(m, w), power_down_go)
            `CHK("awake", !exp_hit(m, w), sleeping)
            `CHK("reg_wake", exp_hit(m, w) || exp_reg(m), digital_regulator_on)
            @(negedge core_clk) wake = 0;
            `CHK("mode", m, power_down_mode_select)
            `CHK("reconf_set", m > 2'h1, reconfig_required)
        end
        final_report();
    end
endmodule : tb_top
